// File: hdl/standstill_position_monitor.v
// Standstill position monitor with AXI4-Lite configuration and interrupt
`timescale 1ns/1ps
`include "standstill_defs.vh"
module standstill_position_monitor #(
  parameter CLKS_PER_MS = `CLKS_PER_MS,
  parameter CLKS_PER_CYCLE = `CLKS_PER_CYCLE
) (
  input wire clk,
  input wire rst,
  input wire ce,
  input wire arm_input_n,
  input wire [31:0] first_axis_position,
  input wire [31:0] second_axis_position,
  input wire [31:0] first_axis_speed,
  input wire [31:0] second_axis_speed,
  output reg standstill_ok_out,
  output reg braking_stop_request,
  output reg irq,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready
);
  localparam ST_IDLE = 2'b00;
  localparam ST_DELAY = 2'b01;
  localparam ST_MONITOR = 2'b10;
  localparam ST_FAULT = 2'b11;

  // Configuration and status
  reg [`CTRL_WIDTH-1:0] ctrl;
  reg [`DELAY_WIDTH-1:0] on_delay;
  reg [`WINDOW_WIDTH-1:0] window;
  reg [`SPEED_WIDTH-1:0] auto_speed;
  reg [`EVT_WIDTH-1:0] int_status;
  reg [`EVT_WIDTH-1:0] int_enable;
  reg [`EVT_WIDTH-1:0] int_clear;
  reg [31:0] start_pos;
  reg [1:0] state;
  reg [`EVT_WIDTH-1:0] events;

  // Bus holding registers
  reg [7:0] aw_addr;
  reg aw_held;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  reg w_held;

  wire armed_n;
  wire armed = ~armed_n;
  wire timer_done;
  wire axis_second = ctrl[`CTRL_AXIS_BIT];
  wire monitor_only = ctrl[`CTRL_MONITOR_ONLY_BIT];
  wire auto_start = ctrl[`CTRL_AUTO_START_BIT];

  input_sync #(
    .WIDTH(1),
    .RESET_VALUE(1'b1)
  ) arm_sync (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .async_in(arm_input_n),
    .sync_out(armed_n)
  );

  // Start and stop pulses for the delay
  wire arm_start = armed && (state == ST_IDLE);
  wire disarm = !armed && (state != ST_IDLE);

  on_delay_timer #(
    .CLKS_PER_MS(CLKS_PER_MS),
    .CLKS_PER_CYCLE(CLKS_PER_CYCLE)
  ) delay_timer (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .restart(arm_start),
    .stop(disarm),
    .delay_ms(on_delay),
    .done(timer_done),
    .cycle_tick()
  );

  // Axis selection
  wire [31:0] position = axis_second ? second_axis_position : first_axis_position;
  wire [31:0] speed = axis_second ? second_axis_speed : first_axis_speed;

  // Speed magnitude against the auto-start threshold
  wire [32:0] speed_ext = {speed[31], speed};
  wire [32:0] speed_abs = speed[31] ? (33'h0_0000_0000 - speed_ext) : speed_ext;
  wire speed_below = (speed_abs < {9'h000, auto_speed});

  // Deviation is kept in 33 bits so a full-range swing cannot wrap into the window
  wire [32:0] pos_diff = {position[31], position} - {start_pos[31], start_pos};
  wire [32:0] pos_abs = pos_diff[32] ? (33'h0_0000_0000 - pos_diff) : pos_diff;
  wire window_violation = (pos_abs > {2'b00, window});

  wire early_start = auto_start && speed_below;
  wire begin_monitor = (state == ST_DELAY) && armed && (timer_done || early_start);

  // Monitoring sequence
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= ST_IDLE;
      start_pos <= 32'h0000_0000;
      standstill_ok_out <= 1'b0;
      braking_stop_request <= 1'b0;
      events <= {`EVT_WIDTH{1'b0}};
    end else if (ce) begin
      events <= {`EVT_WIDTH{1'b0}};
      case (state)
        ST_IDLE: begin
          standstill_ok_out <= 1'b0;
          braking_stop_request <= 1'b0;
          if (armed)
            state <= ST_DELAY;
        end
        ST_DELAY: begin
          standstill_ok_out <= 1'b0;
          if (!armed) begin
            state <= ST_IDLE;
          end else if (begin_monitor) begin
            start_pos <= position;
            state <= ST_MONITOR;
            standstill_ok_out <= 1'b1;
            events[`EVT_MON_START] <= 1'b1;
            events[`EVT_AUTO_START] <= !timer_done;
          end
        end
        ST_MONITOR: begin
          if (!armed) begin
            state <= ST_IDLE;
            standstill_ok_out <= 1'b0;
          end else if (window_violation) begin
            state <= ST_FAULT;
            standstill_ok_out <= 1'b0;
            braking_stop_request <= !monitor_only;
            events[`EVT_VIOLATION] <= 1'b1;
          end else begin
            standstill_ok_out <= 1'b1;
          end
        end
        ST_FAULT: begin
          // Fault is latched until the function is disarmed
          standstill_ok_out <= 1'b0;
          if (!armed) begin
            state <= ST_IDLE;
            braking_stop_request <= 1'b0;
          end
        end
        default: begin
          state <= ST_IDLE;
          standstill_ok_out <= 1'b0;
          braking_stop_request <= 1'b0;
        end
      endcase
    end
  end

  // Interrupt status: a new event wins over a clear in the same cycle
  wire [`EVT_WIDTH-1:0] next_int_status = (int_status & ~int_clear) | events;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      int_status <= {`EVT_WIDTH{1'b0}};
      irq <= 1'b0;
    end else if (ce) begin
      int_status <= next_int_status;
      irq <= |(next_int_status & int_enable);
    end
  end

  // Byte-lane merge for writes
  function [31:0] merge_bytes;
    input [31:0] old_value;
    input [31:0] new_value;
    input [3:0] strb;
    integer b;
    begin
      merge_bytes = old_value;
      for (b = 0; b < 4; b = b + 1) begin
        if (strb[b])
          merge_bytes[b*8 +: 8] = new_value[b*8 +: 8];
      end
    end
  endfunction

  wire [31:0] ctrl_merged = merge_bytes({29'h0000_0000, ctrl}, w_data, w_strb);
  wire [31:0] delay_merged = merge_bytes({15'h0000, on_delay}, w_data, w_strb);
  wire [31:0] window_merged = merge_bytes({1'b0, window}, w_data, w_strb);
  wire [31:0] speed_merged = merge_bytes({8'h00, auto_speed}, w_data, w_strb);
  wire [31:0] enable_merged = merge_bytes({29'h0000_0000, int_enable}, w_data, w_strb);
  wire [31:0] clear_merged = merge_bytes(32'h0000_0000, w_data, w_strb);

  wire do_write = aw_held && w_held && !s_axi_bvalid;
  wire write_mapped = (aw_addr == `ADDR_CTRL) || (aw_addr == `ADDR_ON_DELAY) ||
                      (aw_addr == `ADDR_WINDOW) || (aw_addr == `ADDR_AUTO_SPEED) ||
                      (aw_addr == `ADDR_INT_ENABLE) || (aw_addr == `ADDR_INT_CLEAR);

  // Write channels: address and data taken in either order, answered together
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
      aw_addr <= 8'h00;
      aw_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      w_held <= 1'b0;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr <= {s_axi_awaddr[7:2], 2'b00};
        aw_held <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        w_held <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= write_mapped ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Configuration registers
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl <= `RST_CTRL;
      on_delay <= `RST_ON_DELAY;
      window <= `RST_WINDOW;
      auto_speed <= `RST_AUTO_SPEED;
      int_enable <= {`EVT_WIDTH{1'b0}};
      int_clear <= {`EVT_WIDTH{1'b0}};
    end else if (ce) begin
      int_clear <= {`EVT_WIDTH{1'b0}};
      if (do_write) begin
        case (aw_addr)
          `ADDR_CTRL: ctrl <= ctrl_merged[`CTRL_WIDTH-1:0];
          `ADDR_ON_DELAY: begin
            // Out-of-range delays saturate at the longest allowed delay
            if (delay_merged > {15'h0000, `MAX_ON_DELAY})
              on_delay <= `MAX_ON_DELAY;
            else
              on_delay <= delay_merged[`DELAY_WIDTH-1:0];
          end
          `ADDR_WINDOW: window <= window_merged[`WINDOW_WIDTH-1:0];
          `ADDR_AUTO_SPEED: auto_speed <= speed_merged[`SPEED_WIDTH-1:0];
          `ADDR_INT_ENABLE: int_enable <= enable_merged[`EVT_WIDTH-1:0];
          `ADDR_INT_CLEAR: int_clear <= clear_merged[`EVT_WIDTH-1:0];
          default: ctrl <= ctrl;
        endcase
      end
    end
  end

  // Read data selection
  reg [31:0] read_value;
  reg read_mapped;
  wire [7:0] rd_addr = {s_axi_araddr[7:2], 2'b00};

  always @* begin
    read_value = 32'h0000_0000;
    read_mapped = 1'b1;
    case (rd_addr)
      `ADDR_CTRL: read_value = {29'h0000_0000, ctrl};
      `ADDR_ON_DELAY: read_value = {15'h0000, on_delay};
      `ADDR_WINDOW: read_value = {1'b0, window};
      `ADDR_AUTO_SPEED: read_value = {8'h00, auto_speed};
      `ADDR_STATUS: begin
        read_value[`STAT_ARMED_BIT] = armed;
        read_value[`STAT_OK_BIT] = standstill_ok_out;
        read_value[`STAT_BRAKE_BIT] = braking_stop_request;
        read_value[`STAT_FAULT_BIT] = (state == ST_FAULT);
        read_value[`STAT_STATE_LSB +: 2] = state;
      end
      `ADDR_START_POS: read_value = start_pos;
      `ADDR_INT_STATUS: read_value = {29'h0000_0000, int_status};
      `ADDR_INT_ENABLE: read_value = {29'h0000_0000, int_enable};
      `ADDR_INT_CLEAR: read_value = 32'h0000_0000;
      default: read_mapped = 1'b0;
    endcase
  end

  // Read channel answers one cycle after the address is taken
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `RESP_OKAY;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= read_value;
        s_axi_rresp <= read_mapped ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end
endmodule

// File: hdl/standstill_defs.vh
// Constants for the standstill position monitor: map, fields, resets, timing
`ifndef STANDSTILL_DEFS_VH
`define STANDSTILL_DEFS_VH

// Clock and timing
`define CLK_HZ 20000000
`define MS_PER_S 1000
`define US_PER_S 1000000
`define CYCLE_TIME_US 2000
`define CLKS_PER_MS (`CLK_HZ / `MS_PER_S)
`define CLKS_PER_CYCLE ((`CLK_HZ / `US_PER_S) * `CYCLE_TIME_US)

// Register byte addresses
`define ADDR_CTRL 8'h00
`define ADDR_ON_DELAY 8'h04
`define ADDR_WINDOW 8'h08
`define ADDR_AUTO_SPEED 8'h0C
`define ADDR_STATUS 8'h10
`define ADDR_START_POS 8'h14
`define ADDR_INT_STATUS 8'h18
`define ADDR_INT_ENABLE 8'h1C
`define ADDR_INT_CLEAR 8'h20

// Control fields
`define CTRL_AXIS_BIT 0
`define CTRL_MONITOR_ONLY_BIT 1
`define CTRL_AUTO_START_BIT 2
`define CTRL_WIDTH 3

// Status fields
`define STAT_ARMED_BIT 0
`define STAT_OK_BIT 1
`define STAT_BRAKE_BIT 2
`define STAT_FAULT_BIT 3
`define STAT_STATE_LSB 4

// Interrupt event bits
`define EVT_MON_START 0
`define EVT_VIOLATION 1
`define EVT_AUTO_START 2
`define EVT_WIDTH 3

// Field widths and reset values
`define DELAY_WIDTH 17
`define WINDOW_WIDTH 31
`define SPEED_WIDTH 24
`define RST_CTRL 3'h0
`define RST_ON_DELAY 17'h0_0064
`define MAX_ON_DELAY 17'h1_D4C0
`define RST_WINDOW 31'h0000_0064
`define RST_AUTO_SPEED 24'h00_0154

// AXI responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// File: hdl/input_sync.v
// Two-flop synchroniser for pins arriving from outside the clock domain
`timescale 1ns/1ps
module input_sync #(
  parameter WIDTH = 1,
  parameter [WIDTH-1:0] RESET_VALUE = {WIDTH{1'b1}}
) (
  input wire clk,
  input wire rst,
  input wire ce,
  input wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : bit_sync
      reg meta;
      reg stable;
      always @(posedge clk or posedge rst) begin
        if (rst) begin
          meta <= RESET_VALUE[i];
          stable <= RESET_VALUE[i];
        end else if (ce) begin
          meta <= async_in[i];
          stable <= meta;
        end
      end
      assign sync_out[i] = stable;
    end
  endgenerate
endmodule

// File: hdl/on_delay_timer.v
// On-delay timer in milliseconds that expires only on a processing-cycle boundary
`timescale 1ns/1ps
`include "standstill_defs.vh"
module on_delay_timer #(
  parameter CLKS_PER_MS = `CLKS_PER_MS,
  parameter CLKS_PER_CYCLE = `CLKS_PER_CYCLE
) (
  input wire clk,
  input wire rst,
  input wire ce,
  input wire restart,
  input wire stop,
  input wire [`DELAY_WIDTH-1:0] delay_ms,
  output reg done,
  output reg cycle_tick
);
  reg [31:0] pre_cnt;
  reg [31:0] cyc_cnt;
  reg [`DELAY_WIDTH-1:0] ms_cnt;
  reg running;
  wire ms_tick = (pre_cnt == CLKS_PER_MS - 1);
  wire cyc_end = (cyc_cnt == CLKS_PER_CYCLE - 1);
  wire elapsed = (ms_cnt >= delay_ms);

  // Processing cycle runs free; the delay is only judged at its boundaries
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cyc_cnt <= 32'h0000_0000;
      cycle_tick <= 1'b0;
    end else if (ce) begin
      cycle_tick <= cyc_end;
      if (cyc_end)
        cyc_cnt <= 32'h0000_0000;
      else
        cyc_cnt <= cyc_cnt + 32'h0000_0001;
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      pre_cnt <= 32'h0000_0000;
      ms_cnt <= {`DELAY_WIDTH{1'b0}};
      running <= 1'b0;
      done <= 1'b0;
    end else if (ce) begin
      done <= 1'b0;
      if (restart || stop) begin
        pre_cnt <= 32'h0000_0000;
        ms_cnt <= {`DELAY_WIDTH{1'b0}};
        running <= restart;
      end else if (running) begin
        if (ms_tick) begin
          pre_cnt <= 32'h0000_0000;
          if (!elapsed)
            ms_cnt <= ms_cnt + {{(`DELAY_WIDTH-1){1'b0}}, 1'b1};
        end else begin
          pre_cnt <= pre_cnt + 32'h0000_0001;
        end
        if (elapsed && cyc_end) begin
          running <= 1'b0;
          done <= 1'b1;
        end
      end
    end
  end
endmodule

// File: tb/standstill_position_monitor_assertions.sv
// Port-level checks for the standstill position monitor
`timescale 1ns/1ps
module standstill_position_monitor_assertions (
  input logic clk,
  input logic rst,
  input logic ce,
  input logic arm_input_n,
  input logic standstill_ok_out,
  input logic braking_stop_request,
  input logic s_axi_awvalid,
  input logic s_axi_awready,
  input logic s_axi_wvalid,
  input logic s_axi_wready,
  input logic [1:0] s_axi_bresp,
  input logic s_axi_bvalid,
  input logic s_axi_bready,
  input logic s_axi_arvalid,
  input logic s_axi_arready,
  input logic [31:0] s_axi_rdata,
  input logic s_axi_rvalid,
  input logic s_axi_rready
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Five samples cover the two-flop synchroniser plus state and output update
  sequence disarmed_s;
    (arm_input_n && ce) [*5];
  endsequence
  sequence write_taken_s;
    ce && s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  a_disarm_drops_ok: assert property (
    disarmed_s |-> !standstill_ok_out && !braking_stop_request) else $error("ok while disarmed");
  a_rearm_waits: assert property (
    $fell(arm_input_n) |-> !standstill_ok_out [*4]) else $error("ok too early");
  a_ok_needs_arm: assert property (
    $rose(standstill_ok_out) |-> !arm_input_n) else $error("ok rose while disarmed");
  a_brake_no_ok: assert property (
    braking_stop_request |-> !standstill_ok_out) else $error("brake with ok high");
  a_fault_latched: assert property (
    braking_stop_request && !arm_input_n |=> braking_stop_request) else $error("brake dropped");
  a_write_answer: assert property (
    write_taken_s |-> ##2 s_axi_bvalid) else $error("write response late");
  a_read_answer: assert property (
    ce && s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read data late");
  a_bresp_holds: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_rdata_holds: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_bus_busy: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("ready while busy");
endmodule

// File: tb/axis_feedback_model.sv
// Drive-side model: axis encoders, speed feedback and the arm contact
`timescale 1ns/1ps
module axis_feedback_model (
  input wire clk,
  input wire rst,
  input wire arm_req,
  input wire [31:0] pos_a,
  input wire [31:0] pos_b,
  input wire [31:0] speed,
  output reg arm_input_n,
  output reg [31:0] first_axis_position,
  output reg [31:0] second_axis_position,
  output reg [31:0] first_axis_speed,
  output reg [31:0] second_axis_speed
);
  // Feedback updates once per clock, as the drive samples its encoders
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      arm_input_n <= 1'h1;
      first_axis_position <= 32'h0;
      second_axis_position <= 32'h0;
      first_axis_speed <= 32'h0;
      second_axis_speed <= 32'h0;
    end else begin
      arm_input_n <= !arm_req;
      first_axis_position <= pos_a;
      second_axis_position <= pos_b;
      first_axis_speed <= speed;
      second_axis_speed <= speed;
    end
  end
endmodule

// File: tb/standstill_position_monitor_tb.sv
// Self-checking bench for the standstill position monitor
`timescale 1ns/1ps
`include "standstill_defs.vh"
module standstill_position_monitor_tb;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic ce = 1'h1;
  logic arm_req = 1'h0;
  logic [31:0] pos_a = 32'h0000_1000;
  logic [31:0] pos_b = 32'hFFFF_FF00;
  logic [31:0] speed = 32'h0000_1000;
  logic [7:0] s_axi_awaddr = 8'h0;
  logic [7:0] s_axi_araddr = 8'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'h0;
  logic s_axi_wvalid = 1'h0;
  logic s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0;
  logic s_axi_rready = 1'h0;
  logic arm_input_n, standstill_ok_out, braking_stop_request, irq;
  logic [31:0] first_axis_position, second_axis_position, first_axis_speed, second_axis_speed;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  integer fails = 0;
  integer check_count = 0;
  integer c;

  axis_feedback_model u_axis_feedback_model (.clk(clk), .rst(rst), .arm_req(arm_req),
    .pos_a(pos_a), .pos_b(pos_b), .speed(speed), .arm_input_n(arm_input_n),
    .first_axis_position(first_axis_position), .second_axis_position(second_axis_position),
    .first_axis_speed(first_axis_speed), .second_axis_speed(second_axis_speed));

  // Short counts keep the millisecond timer and cycle grid inside a brief run
  standstill_position_monitor #(.CLKS_PER_MS(10), .CLKS_PER_CYCLE(25))
    u_standstill_position_monitor (.clk(clk), .rst(rst), .ce(ce), .arm_input_n(arm_input_n),
    .first_axis_position(first_axis_position), .second_axis_position(second_axis_position),
    .first_axis_speed(first_axis_speed), .second_axis_speed(second_axis_speed),
    .standstill_ok_out(standstill_ok_out), .braking_stop_request(braking_stop_request),
    .irq(irq), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

  initial begin
    forever #25 clk = ~clk;
  end

  task give_verdict;
    begin
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
    end
  endtask

  task tmo;
    begin
      fails++;
      give_verdict;
    end
  endtask

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    begin
      check_count++;
      if (seen !== exp) begin
        fails++;
        $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask

  task idle(input integer n);
    begin
      repeat (n) @(posedge clk);
    end
  endtask

  // Ready is raised only after the answer shows, so the slave must hold it
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    integer n;
    logic done;
    begin
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      done = 1'h0;
      for (n = 0; !done; n++) begin
        @(posedge clk);
        if (n > 40) tmo;
        if (s_axi_bvalid && s_axi_bready) begin
          chk({30'h0, s_axi_bresp}, {30'h0, er});
          s_axi_bready <= 1'h0;
          done = 1'h1;
        end else if (s_axi_bvalid) s_axi_bready <= 1'h1;
        if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
        if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
      end
    end
  endtask

  task rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    integer n;
    logic done;
    begin
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      done = 1'h0;
      for (n = 0; !done; n++) begin
        @(posedge clk);
        if (n > 40) tmo;
        if (s_axi_rvalid && s_axi_rready) begin
          chk(s_axi_rdata, ed);
          chk({30'h0, s_axi_rresp}, {30'h0, er});
          s_axi_rready <= 1'h0;
          done = 1'h1;
        end else if (s_axi_rvalid) s_axi_rready <= 1'h1;
        if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
      end
    end
  endtask

  task wait_ok(output integer n);
    begin
      for (n = 0; standstill_ok_out !== 1'h1; n++) begin
        @(posedge clk);
        if (n > 3000) tmo;
      end
    end
  endtask

  task t_regs;
    begin
      rd(`ADDR_CTRL, 32'h0, `RESP_OKAY);
      rd(`ADDR_ON_DELAY, 32'h0000_0064, `RESP_OKAY);
      rd(`ADDR_WINDOW, 32'h0000_0064, `RESP_OKAY);
      rd(`ADDR_AUTO_SPEED, 32'h0000_0154, `RESP_OKAY);
      wr(`ADDR_ON_DELAY, 32'h0003_0D40, `RESP_OKAY);
      rd(`ADDR_ON_DELAY, 32'h0001_D4C0, `RESP_OKAY);
      wr(`ADDR_WINDOW, 32'h7FFF_FFFF, `RESP_OKAY);
      rd(`ADDR_WINDOW, 32'h7FFF_FFFF, `RESP_OKAY);
      rd(8'h24, 32'h0, `RESP_SLVERR);
      wr(`ADDR_STATUS, 32'h1, `RESP_SLVERR);
    end
  endtask

  task t_stop;
    begin
      wr(`ADDR_ON_DELAY, 32'h3, `RESP_OKAY);
      wr(`ADDR_WINDOW, 32'h5, `RESP_OKAY);
      arm_req <= 1'h1;
      wait_ok(c);
      chk({31'h0, c >= 32 && c <= 64}, 32'h1);
      rd(`ADDR_START_POS, 32'h0000_1000, `RESP_OKAY);
      pos_a <= 32'h0000_0FFB;
      idle(4);
      chk({31'h0, standstill_ok_out}, 32'h1);
      pos_a <= 32'h0000_1005;
      idle(4);
      chk({31'h0, standstill_ok_out}, 32'h1);
      pos_a <= 32'h0000_1006;
      idle(4);
      chk({31'h0, standstill_ok_out}, 32'h0);
      chk({31'h0, braking_stop_request}, 32'h1);
      chk({31'h0, irq}, 32'h0);
      wr(`ADDR_INT_ENABLE, 32'h2, `RESP_OKAY);
      idle(2);
      chk({31'h0, irq}, 32'h1);
      rd(`ADDR_INT_STATUS, 32'h3, `RESP_OKAY);
      wr(`ADDR_INT_CLEAR, 32'h3, `RESP_OKAY);
      idle(2);
      chk({31'h0, irq}, 32'h0);
      arm_req <= 1'h0;
      idle(6);
      chk({31'h0, braking_stop_request}, 32'h0);
    end
  endtask

  task t_only;
    begin
      wr(`ADDR_CTRL, 32'h3, `RESP_OKAY);
      wr(`ADDR_ON_DELAY, 32'h0, `RESP_OKAY);
      arm_req <= 1'h1;
      wait_ok(c);
      rd(`ADDR_START_POS, 32'hFFFF_FF00, `RESP_OKAY);
      pos_a <= 32'h0000_5000;
      idle(4);
      chk({31'h0, standstill_ok_out}, 32'h1);
      pos_b <= 32'hFFFF_FEFA;
      idle(4);
      chk({31'h0, standstill_ok_out}, 32'h0);
      chk({31'h0, braking_stop_request}, 32'h0);
      arm_req <= 1'h0;
      idle(8);
      pos_b <= 32'hFFFF_FE00;
      arm_req <= 1'h1;
      wait_ok(c);
      rd(`ADDR_START_POS, 32'hFFFF_FE00, `RESP_OKAY);
      arm_req <= 1'h0;
      idle(8);
    end
  endtask

  task t_auto;
    begin
      wr(`ADDR_CTRL, 32'h4, `RESP_OKAY);
      wr(`ADDR_ON_DELAY, 32'h0001_D4C0, `RESP_OKAY);
      wr(`ADDR_AUTO_SPEED, 32'h0000_0154, `RESP_OKAY);
      wr(`ADDR_INT_CLEAR, 32'h7, `RESP_OKAY);
      speed <= 32'h0000_0154;
      arm_req <= 1'h1;
      idle(60);
      chk({31'h0, standstill_ok_out}, 32'h0);
      speed <= 32'hFFFF_FF9C;
      idle(8);
      chk({31'h0, standstill_ok_out}, 32'h1);
      rd(`ADDR_INT_STATUS, 32'h5, `RESP_OKAY);
      // Clock enable low must freeze the compare even though the axis leaves the window
      ce <= 1'h0;
      pos_a <= 32'h0000_2000;
      idle(6);
      chk({31'h0, standstill_ok_out}, 32'h1);
      chk({31'h0, braking_stop_request}, 32'h0);
      ce <= 1'h1;
      idle(4);
      chk({31'h0, standstill_ok_out}, 32'h0);
      chk({31'h0, braking_stop_request}, 32'h1);
      arm_req <= 1'h0;
      idle(6);
      chk({31'h0, braking_stop_request}, 32'h0);
    end
  endtask

  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    t_regs;
    t_stop;
    t_only;
    t_auto;
    give_verdict;
  end
endmodule

bind standstill_position_monitor standstill_position_monitor_assertions
  u_standstill_position_monitor_assertions (.clk(clk), .rst(rst), .ce(ce),
  .arm_input_n(arm_input_n), .standstill_ok_out(standstill_ok_out),
  .braking_stop_request(braking_stop_request), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
